// ### inc/alin_pkg.sv
// constants, types and decode function for the accumulator load instruction block
package alin_pkg;

    // =====================================================================
    // instruction words
    // =====================================================================
    localparam logic [9:0] ALIN_OPC_PRESCALER = 10'h275;
    localparam logic [9:0] ALIN_OPC_POINTER_D = 10'h051;
    localparam logic [9:0] ALIN_OPC_INT_CTRL = 10'h253;
    localparam logic [9:0] ALIN_OPC_WAKE0 = 10'h256;
    localparam logic [9:0] ALIN_OPC_WAKE1 = 10'h259;
    localparam logic [9:0] ALIN_OPC_WAKE2 = 10'h25a;

    // =====================================================================
    // register map (byte addresses) and fields
    // =====================================================================
    localparam logic [7:0] ALIN_ADR_INSTR = 8'h00;
    localparam logic [7:0] ALIN_ADR_ACC = 8'h04;
    localparam logic [7:0] ALIN_ADR_REG_B = 8'h08;
    localparam logic [7:0] ALIN_ADR_CARRY = 8'h0c;
    localparam logic [7:0] ALIN_ADR_STATUS = 8'h10;
    localparam int unsigned ALIN_ST_HIT = 0;
    localparam int unsigned ALIN_ST_PEND = 1;
    localparam int unsigned ALIN_ST_OP_LSB = 8;
    localparam int unsigned ALIN_ST_WORD_LSB = 16;
    localparam logic [3:0] ALIN_RST_ACC = 4'h0;
    localparam logic [3:0] ALIN_RST_REG_B = 4'h0;
    localparam logic ALIN_RST_CARRY = 1'b0;
    localparam logic [9:0] ALIN_RST_WORD = 10'h000;
    localparam logic [31:0] ALIN_RD_ZERO = 32'h0000_0000;

    // =====================================================================
    // types
    // =====================================================================
    typedef enum logic [6:0] {
        ALIN_OP_NONE = 7'h01,
        ALIN_OP_PS = 7'h02,
        ALIN_OP_D = 7'h04,
        ALIN_OP_I1 = 7'h08,
        ALIN_OP_K0 = 7'h10,
        ALIN_OP_K1 = 7'h20,
        ALIN_OP_K2 = 7'h40
    } alin_op_t;

    typedef struct packed {
        logic [7:0] prescaler_count;
        logic [2:0] data_pointer_d;
        logic [3:0] int_ctrl_reg;
        logic [3:0] wake_ctrl_reg0;
        logic [3:0] wake_ctrl_reg1;
        logic [3:0] wake_ctrl_reg2;
    } alin_src_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } alin_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } alin_wb_rsp_t;

    // =====================================================================
    // decode
    // =====================================================================
    function automatic alin_op_t alin_decode_f(input logic [9:0] word);
        alin_op_t op;
        op = ALIN_OP_NONE;
        if (word == ALIN_OPC_PRESCALER) op = ALIN_OP_PS;
        if (word == ALIN_OPC_POINTER_D) op = ALIN_OP_D;
        if (word == ALIN_OPC_INT_CTRL) op = ALIN_OP_I1;
        if (word == ALIN_OPC_WAKE0) op = ALIN_OP_K0;
        if (word == ALIN_OPC_WAKE1) op = ALIN_OP_K1;
        if (word == ALIN_OPC_WAKE2) op = ALIN_OP_K2;
        return op;
    endfunction : alin_decode_f

endpackage : alin_pkg

// ### design/alin_decode.sv
// instruction word decoder for the accumulator load group
`timescale 1ns/1ps
module alin_decode import alin_pkg::*; (
    // instruction word in
    input wire logic [9:0] word,
    // decoded operation out
    output alin_op_t op,
    output logic hit
);

    // =====================================================================
    // decode
    // =====================================================================
    always_comb begin
        op = alin_decode_f(word);
        hit = (op != ALIN_OP_NONE);
    end

endmodule : alin_decode

// ### design/alin_top.sv
// accumulator load instruction executor with wishbone register access
// Notes on behaviour
// - prescaler high nibble to B, low to accumulator
// - pointer D to accumulator bits 2-0, bit3 zero
// - word 253 copies interrupt control to accumulator
// - word 256 copies wake control zero
// - word 259 copies wake control one
// - word 25a copies wake control two
`timescale 1ns/1ps
module alin_top import alin_pkg::*; (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // core instruction port
    input wire logic instr_valid,
    input wire logic [9:0] instr_word,
    // source registers from the peripherals
    input wire alin_src_t src,
    // core results
    output logic [3:0] acc,
    output logic [3:0] reg_b,
    output logic carry_flag,
    output logic exec_done,
    // wishbone slave
    input wire alin_wb_req_t wb_req,
    output alin_wb_rsp_t wb_rsp
);

    // =====================================================================
    // declarations
    // =====================================================================
    logic [3:0] acc_q, acc_d;
    logic [3:0] reg_b_q, reg_b_d;
    logic carry_q, carry_d;
    logic done_q, done_d;
    logic hit_q, hit_d;
    alin_op_t last_op_q, last_op_d;
    logic [9:0] last_word_q, last_word_d;
    logic pend_q, pend_d;
    logic [9:0] bus_word_q, bus_word_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic req;
    logic commit;
    logic wr_lo;
    logic fire;
    logic [9:0] cur_word;
    alin_op_t cur_op;
    logic cur_hit;

    // =====================================================================
    // instruction select and decode
    // =====================================================================
    // the core port has priority; a bus-issued word waits in bus_word_q while pend_q is set
    assign fire = instr_valid | pend_q;
    assign cur_word = instr_valid ? instr_word : bus_word_q;

    alin_decode u_decode (
        .word(cur_word),
        .op(cur_op),
        .hit(cur_hit)
    );

    // =====================================================================
    // wishbone slave
    // =====================================================================
    assign req = wb_req.cyc & wb_req.stb;
    // a write takes effect at the edge where ack is seen high
    assign commit = req & ack_q & wb_req.we;
    assign wr_lo = commit & wb_req.sel[0];

    always_comb begin
        ack_d = 1'b0;
        rdat_d = rdat_q;
        if (req && !ack_q) begin
            // an instruction write stalls while a bus word is still pending
            ack_d = !(wb_req.we && wb_req.adr == ALIN_ADR_INSTR && pend_q);
            rdat_d = ALIN_RD_ZERO;
            unique case (wb_req.adr)
                ALIN_ADR_INSTR: rdat_d[9:0] = bus_word_q;
                ALIN_ADR_ACC: rdat_d[3:0] = acc_q;
                ALIN_ADR_REG_B: rdat_d[3:0] = reg_b_q;
                ALIN_ADR_CARRY: rdat_d[0] = carry_q;
                ALIN_ADR_STATUS: begin
                    rdat_d[ALIN_ST_HIT] = hit_q;
                    rdat_d[ALIN_ST_PEND] = pend_q;
                    rdat_d[ALIN_ST_OP_LSB +: 7] = last_op_q;
                    rdat_d[ALIN_ST_WORD_LSB +: 10] = last_word_q;
                end
                default: rdat_d = ALIN_RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
            rdat_q <= ALIN_RD_ZERO;
        end else if (ce) begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_rsp.ack = ack_q;
    assign wb_rsp.dat = rdat_q;

    // =====================================================================
    // bus instruction holding register
    // =====================================================================
    always_comb begin
        pend_d = pend_q;
        bus_word_d = bus_word_q;
        if (pend_q && !instr_valid) begin
            pend_d = 1'b0;
        end
        if (commit && wb_req.adr == ALIN_ADR_INSTR) begin
            pend_d = 1'b1;
            if (wb_req.sel[0]) bus_word_d[7:0] = wb_req.dat[7:0];
            if (wb_req.sel[1]) bus_word_d[9:8] = wb_req.dat[9:8];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_q <= 1'b0;
            bus_word_q <= ALIN_RST_WORD;
        end else if (ce) begin
            pend_q <= pend_d;
            bus_word_q <= bus_word_d;
        end
    end

    // =====================================================================
    // execution: accumulator, register B, carry
    // =====================================================================
    always_comb begin
        acc_d = acc_q;
        reg_b_d = reg_b_q;
        carry_d = carry_q;
        done_d = 1'b0;
        hit_d = hit_q;
        last_op_d = last_op_q;
        last_word_d = last_word_q;
        if (wr_lo && wb_req.adr == ALIN_ADR_ACC) acc_d = wb_req.dat[3:0];
        if (wr_lo && wb_req.adr == ALIN_ADR_REG_B) reg_b_d = wb_req.dat[3:0];
        if (wr_lo && wb_req.adr == ALIN_ADR_CARRY) carry_d = wb_req.dat[0];
        if (fire) begin
            // carry is only ever written from the bus, never by these loads
            done_d = cur_hit;
            hit_d = cur_hit;
            last_op_d = cur_op;
            last_word_d = cur_word;
            // sources are sampled only; no strobe goes back to them
            unique case (cur_op)
                ALIN_OP_PS: begin
                    reg_b_d = src.prescaler_count[7:4];
                    acc_d = src.prescaler_count[3:0];
                end
                ALIN_OP_D: acc_d = {1'b0, src.data_pointer_d};
                ALIN_OP_I1: acc_d = src.int_ctrl_reg;
                ALIN_OP_K0: acc_d = src.wake_ctrl_reg0;
                ALIN_OP_K1: acc_d = src.wake_ctrl_reg1;
                ALIN_OP_K2: acc_d = src.wake_ctrl_reg2;
                ALIN_OP_NONE: acc_d = acc_d;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_q <= ALIN_RST_ACC;
            reg_b_q <= ALIN_RST_REG_B;
            carry_q <= ALIN_RST_CARRY;
            done_q <= 1'b0;
            hit_q <= 1'b0;
            last_op_q <= ALIN_OP_NONE;
            last_word_q <= ALIN_RST_WORD;
        end else if (ce) begin
            acc_q <= acc_d;
            reg_b_q <= reg_b_d;
            carry_q <= carry_d;
            done_q <= done_d;
            hit_q <= hit_d;
            last_op_q <= last_op_d;
            last_word_q <= last_word_d;
        end
    end

    assign acc = acc_q;
    assign reg_b = reg_b_q;
    assign carry_flag = carry_q;
    assign exec_done = done_q;

    // =====================================================================
    // assertions
    // =====================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic bus_carry_wr;
    logic bus_b_wr;
    assign bus_carry_wr = wr_lo && wb_req.adr == ALIN_ADR_CARRY;
    assign bus_b_wr = wr_lo && wb_req.adr == ALIN_ADR_REG_B;

    sequence s_run(logic [9:0] w);
        ce && fire && cur_word == w && !bus_carry_wr;
    endsequence

    sequence s_done;
        exec_done ##0 carry_flag == $past(carry_flag);
    endsequence

    property p_ps_load;
        s_run(ALIN_OPC_PRESCALER) |=> reg_b == $past(src.prescaler_count[7:4])
            && acc == $past(src.prescaler_count[3:0]) ##0 s_done;
    endproperty
    a_ps_load: assert property (p_ps_load) else $error("prescaler load wrong");

    property p_ptr_load;
        s_run(ALIN_OPC_POINTER_D) |=> acc[3] == 1'b0
            && acc[2:0] == $past(src.data_pointer_d) ##0 s_done;
    endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("pointer load wrong");

    property p_int_load;
        s_run(ALIN_OPC_INT_CTRL) |=> acc == $past(src.int_ctrl_reg) ##0 s_done;
    endproperty
    a_int_load: assert property (p_int_load) else $error("int ctrl load wrong");

    property p_wake0_load;
        s_run(ALIN_OPC_WAKE0) |=> acc == $past(src.wake_ctrl_reg0) && exec_done;
    endproperty
    a_wake0_load: assert property (p_wake0_load) else $error("wake0 load wrong");

    property p_wake1_load;
        s_run(ALIN_OPC_WAKE1) |=> acc == $past(src.wake_ctrl_reg1)
            && carry_flag == $past(carry_flag);
    endproperty
    a_wake1_load: assert property (p_wake1_load) else $error("wake1 load wrong");

    property p_wake2_load;
        s_run(ALIN_OPC_WAKE2) |=> acc == $past(src.wake_ctrl_reg2) ##0 s_done;
    endproperty
    a_wake2_load: assert property (p_wake2_load) else $error("wake2 load wrong");

    property p_no_side;
        ce && fire && cur_op != ALIN_OP_PS && !bus_b_wr |=> $stable(reg_b);
    endproperty
    a_no_side: assert property (p_no_side) else $error("load disturbed reg b");

    property p_unknown;
        ce && fire && !cur_hit && !wr_lo |=> $stable(acc) && $stable(reg_b) && !exec_done;
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown word changed state");

    property p_carry_hold;
        ce && !bus_carry_wr |=> $stable(carry_flag);
    endproperty
    a_carry_hold: assert property (p_carry_hold) else $error("carry changed");

    property p_done_idle;
        ce && !fire |=> !exec_done;
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("done without an instruction");

    // a frozen block keeps every register, bus answer included
    property p_freeze;
        !ce |=> $stable(acc) && $stable(reg_b) && $stable(carry_flag)
            && $stable(exec_done) && $stable(wb_rsp.ack);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while ce low");

    property p_ack_idle;
        ce && !req |=> !wb_rsp.ack;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");

    property p_ack_pulse;
        ce && wb_rsp.ack |=> !wb_rsp.ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

    logic instr_blocked;
    assign instr_blocked = wb_req.we && wb_req.adr == ALIN_ADR_INSTR && pend_q;

    property p_ack_answer;
        ce && req && !ack_q && !instr_blocked |=> wb_rsp.ack;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not answered");

    property p_instr_stall;
        ce && req && !ack_q && instr_blocked |=> !wb_rsp.ack;
    endproperty
    a_instr_stall: assert property (p_instr_stall) else $error("second bus word not held off");

    sequence s_bus_queue;
        ce && commit && wb_req.adr == ALIN_ADR_INSTR;
    endsequence

    sequence s_port_free;
        ce && !instr_valid;
    endsequence

    property p_bus_exec;
        s_bus_queue ##1 s_port_free |=> !pend_q && last_word_q == $past(bus_word_q);
    endproperty
    a_bus_exec: assert property (p_bus_exec) else $error("queued bus word not executed");

endmodule : alin_top

// ### verification/alin_tb.sv
// self-checking testbench for the accumulator load instruction block
`timescale 1ns/1ps
module tb;
    import alin_pkg::*;

    // =====================================================================
    // signals
    // =====================================================================
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic instr_valid = 1'b0;
    logic [9:0] instr_word = 10'h000;
    alin_src_t src = '{8'ha5, 3'h7, 4'h9, 4'hc, 4'h3, 4'he};
    logic [3:0] acc;
    logic [3:0] reg_b;
    logic carry_flag;
    logic exec_done;
    alin_wb_req_t wb_req = '0;
    alin_wb_rsp_t wb_rsp;
    int errors = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic [9:0] words [6];
    logic [3:0] exp_acc [6];
    logic [3:0] exp_b [6];

    always #5 clk = ~clk;

    alin_top alin_top_i (
        .clk(clk), .rst_b(rst_b), .ce(ce),
        .instr_valid(instr_valid), .instr_word(instr_word), .src(src),
        .acc(acc), .reg_b(reg_b), .carry_flag(carry_flag), .exec_done(exec_done),
        .wb_req(wb_req), .wb_rsp(wb_rsp)
    );

    // =====================================================================
    // tasks
    // =====================================================================
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask : chk

    // one classic wishbone cycle, held until ack is sampled
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                           output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge clk);
        wb_req <= '{1'b1, 1'b1, we, adr, 4'hf, wd};
        do begin
            @(posedge clk);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 50);
        rdat = wb_rsp.dat;
        wb_req <= '0;
        if (n >= 50) begin
            errors++;
            tally_and_finish();
        end
    endtask : wb_xfer

    // issue one word on the core port for one cycle, look after the executing edge
    task automatic exec(input logic [9:0] w);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_word <= w;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
    endtask : exec

    // =====================================================================
    // main sequence
    // =====================================================================
    initial begin
        words = '{ALIN_OPC_PRESCALER, ALIN_OPC_INT_CTRL, ALIN_OPC_POINTER_D,
                  ALIN_OPC_WAKE0, ALIN_OPC_WAKE1, ALIN_OPC_WAKE2};
        exp_acc = '{4'h5, 4'h9, 4'h7, 4'hc, 4'h3, 4'he};
        exp_b = '{4'ha, 4'ha, 4'ha, 4'ha, 4'ha, 4'ha};
        repeat (8) @(posedge clk);
        chk({acc, reg_b, 3'h0, carry_flag}, 32'h0);
        rst_b <= 1'b1;
        $display("test reset done");
        // carry set by bus must survive every load
        wb_xfer(1'b1, ALIN_ADR_CARRY, 32'h1, rd);
        for (int i = 0; i < 6; i++) begin
            exec(words[i]);
            chk(acc, exp_acc[i]);
            chk(reg_b, exp_b[i]);
            chk(carry_flag, 1'b1);
            chk(exec_done, 1'b1);
        end
        @(posedge clk);
        #1;
        chk(exec_done, 1'b0);
        $display("test core loads done");
        // unrecognised word leaves accumulator and register B alone and raises no done
        exec(10'h3ff);
        chk({exec_done, reg_b, acc}, {1'b0, 4'ha, 4'he});
        $display("test unknown word done");
        // word queued through the bus executes like the core port
        @(posedge clk);
        src.int_ctrl_reg <= 4'h6;
        wb_xfer(1'b1, ALIN_ADR_INSTR, {22'h0, ALIN_OPC_INT_CTRL}, rd);
        repeat (2) @(posedge clk);
        #1;
        chk(acc, 4'h6);
        wb_xfer(1'b0, ALIN_ADR_ACC, 32'h0, rd);
        chk(rd, 32'h6);
        wb_xfer(1'b0, ALIN_ADR_STATUS, 32'h0, rd);
        chk(rd, 32'h0253_0801);
        wb_xfer(1'b0, ALIN_ADR_CARRY, 32'h0, rd);
        chk(rd, 32'h1);
        wb_xfer(1'b0, 8'h14, 32'h0, rd);
        chk(rd, ALIN_RD_ZERO);
        $display("test bus access done");
        // a bus word waits while the core port stays busy
        @(posedge clk);
        instr_word <= 10'h3ff;
        instr_valid <= 1'b1;
        wb_xfer(1'b1, ALIN_ADR_INSTR, {22'h0, ALIN_OPC_WAKE0}, rd);
        wb_xfer(1'b0, ALIN_ADR_STATUS, 32'h0, rd);
        chk(rd, 32'h03ff_0102);
        fork
            wb_xfer(1'b1, ALIN_ADR_INSTR, {22'h0, ALIN_OPC_WAKE1}, rd);
            begin
                repeat (4) @(posedge clk);
                instr_valid <= 1'b0;
            end
        join
        #1;
        chk(acc, 4'hc);
        @(posedge clk);
        #1;
        chk(acc, 4'h3);
        chk(exec_done, 1'b1);
        $display("test queued word done");
        // a low enable freezes the block with a word on the port
        @(posedge clk);
        ce <= 1'b0;
        instr_word <= ALIN_OPC_POINTER_D;
        instr_valid <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({exec_done, acc}, {1'b0, 4'h3});
        @(posedge clk);
        ce <= 1'b1;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        chk(acc, 4'h7);
        chk(exec_done, 1'b1);
        $display("test clock enable done");
        // bus writes reach the accumulator and register B and the last bus word reads back
        wb_xfer(1'b1, ALIN_ADR_ACC, 32'hb, rd);
        wb_xfer(1'b0, ALIN_ADR_ACC, 32'h0, rd);
        chk(rd, 32'hb);
        wb_xfer(1'b1, ALIN_ADR_REG_B, 32'h4, rd);
        wb_xfer(1'b0, ALIN_ADR_REG_B, 32'h0, rd);
        chk(rd, 32'h4);
        wb_xfer(1'b0, ALIN_ADR_INSTR, 32'h0, rd);
        chk(rd, {22'h0, ALIN_OPC_WAKE1});
        chk(carry_flag, 1'b1);
        $display("test register access done");
        tally_and_finish();
    end

endmodule : tb
